// ==== hw/uefp_pkg.sv ====
// Package for the endpoint FIFO block: register map, size codes, state record.
// Assumes a 32-bit AXI4-Lite master and a single 40 MHz clock domain.
package uefp_pkg;

  localparam int unsigned      NUM_FIFO       = 4;
  localparam int unsigned      MEM_BYTES      = 64;
  localparam logic [5:0]       PART_BYTES     = 6'h10;
  localparam logic [5:0]       WIDE_BYTES     = 6'h20;

  // Register byte offsets on the bus.
  localparam logic [7:0]       OFS_SIZE_CFG   = 8'h00;
  localparam logic [7:0]       OFS_EP0_IN     = 8'h04;
  localparam logic [7:0]       OFS_EP0_OUT    = 8'h08;
  localparam logic [7:0]       OFS_EP1_IN     = 8'h0C;
  localparam logic [7:0]       OFS_EP2_DATA   = 8'h10;
  localparam logic [7:0]       OFS_TX_ENABLE  = 8'h14;
  localparam logic [7:0]       OFS_DIRECTION  = 8'h18;
  localparam logic [7:0]       OFS_SOFT_RESET = 8'h1C;
  localparam logic [7:0]       OFS_STATUS     = 8'h20;

  // Size code field and values.
  localparam int unsigned      EP1_SZ_LSB     = 4;
  localparam int unsigned      EP2_SZ_LSB     = 0;
  localparam logic [3:0]       SZ_ZERO        = 4'h0;
  localparam logic [3:0]       SZ_16          = 4'h4;
  localparam logic [3:0]       SZ_32          = 4'h5;
  localparam logic [7:0]       SIZE_CFG_RST   = 8'h44;

  // Transmit enable bits, direction register layout.
  localparam int unsigned      TE_EP0_BIT     = 1;
  localparam int unsigned      TE_EP1_BIT     = 2;
  localparam int unsigned      TE_EP2_BIT     = 3;
  localparam int unsigned      EP2_DIR_BIT    = 3;
  localparam logic [7:0]       DIR_FIXED_ONES = 8'hF4;
  localparam logic             EP2_DIR_RST    = 1'b1;
  localparam int unsigned      SOFT_RST_BIT   = 0;

  // Status register fields.
  localparam int unsigned      ST_EP0_LSB     = 0;
  localparam int unsigned      ST_EP2_LSB     = 8;

  localparam logic [1:0]       RESP_OKAY      = 2'h0;
  localparam logic [1:0]       RESP_DECERR    = 2'h3;

  typedef struct packed {
    logic [63:0][7:0] mem;
    logic [3:0][5:0]  wp;
    logic [3:0][5:0]  wc;
    logic [3:0][5:0]  rp;
    logic [3:0][5:0]  rc;
    logic [7:0]       size_cfg;
    logic             ep2_dir;
    logic             awrdy;
    logic             bvld;
    logic [1:0]       bresp;
    logic             arrdy;
    logic             rvld;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
    logic [7:0]       eng_data;
    logic             eng_dv;
    logic [3:0]       in_rdy;
    logic [3:0]       out_room;
  } uefp_state_t;

  localparam uefp_state_t STATE_RST = '{
    mem: '0, wp: '0, wc: '0, rp: '0, rc: '0,
    size_cfg: SIZE_CFG_RST, ep2_dir: EP2_DIR_RST,
    awrdy: 1'b0, bvld: 1'b0, bresp: 2'h0, arrdy: 1'b0, rvld: 1'b0, rresp: 2'h0,
    rdata: 32'h00000000, eng_data: 8'h00, eng_dv: 1'b0, in_rdy: 4'h0, out_room: 4'h0
  };

endpackage : uefp_pkg

// ==== hw/uefp_top.sv ====
// Endpoint FIFO block: 64-byte store split per endpoint, CPU data ports over
// AXI4-Lite and a byte port towards the USB function engine.
// Assumes the engine drives its strobes synchronous to REF_CLK, one at a time per side.
//
// Behaviour
// - 64 bytes as four 16-byte FIFOs.
// - Endpoint 1 may take 32 bytes.
// - Packet limit is half the FIFO.
// - Endpoint 0 FIFOs fixed at 16 bytes.
// - Size register: EP1 high, EP2 low nibble.
// - Only codes zero, sixteen, thirty-two accepted.
// - Size register resets to 44 hex.
// - EP0 IN and EP1 ports write-only.
// - EP0 OUT port read-only, writes ignored.
// - EP2 port direction follows direction bit.
// - IN bytes valid after transmit enable.
// - OUT bytes valid after ACK.
// - OUT bytes read in arrival order.
// - Data ports read zero after reset.
// - Transmit enable write-one, reads zero.
// - Transfer error rewinds the FIFO.
// - EP2 direction: zero out, one in.
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

module uefp_top (
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic [1:0]  ENG_RD_EP,
  input  wire logic        ENG_RD,
  input  wire logic        ENG_IN_ACK,
  input  wire logic        ENG_IN_ERR,
  output logic [7:0]       ENG_RD_DATA,
  output logic             ENG_RD_VALID,
  input  wire logic [1:0]  ENG_WR_EP,
  input  wire logic        ENG_WR,
  input  wire logic [7:0]  ENG_WR_DATA,
  input  wire logic        ENG_OUT_ACK,
  input  wire logic        ENG_OUT_ERR,
  output logic [3:0]       ENG_IN_READY,
  output logic [3:0]       ENG_OUT_ROOM
);

  uefp_pkg::uefp_state_t st_reg;
  uefp_pkg::uefp_state_t st_next;

  ////////////////////////////////////////////////////////////////////////////////
  // Partition geometry.

  function automatic logic [5:0] fifo_size(input logic [7:0] cfg, input logic [1:0] i);
    logic [5:0] sz;
    sz = uefp_pkg::PART_BYTES;
    if (i == 2'h2 && cfg[uefp_pkg::EP1_SZ_LSB +: 4] == uefp_pkg::SZ_32) begin
      sz = uefp_pkg::WIDE_BYTES;
    end
    if (i == 2'h3 && cfg[uefp_pkg::EP2_SZ_LSB +: 4] == uefp_pkg::SZ_ZERO) begin
      sz = 6'h00;
    end
    return sz;
  endfunction : fifo_size

  function automatic logic is_out(input logic dir, input logic [1:0] i);
    return (i == 2'h1) || (i == 2'h3 && !dir);
  endfunction : is_out

  // Endpoint 2 storage sits directly above a 16-byte endpoint 1, so a 32-byte
  // endpoint 1 simply grows into it.
  function automatic logic [5:0] byte_addr(input logic [7:0] cfg, input logic [1:0] i,
                                           input logic [5:0] pos);
    logic [5:0] msk;
    msk = fifo_size(cfg, i) - 6'h01;
    return {i, 4'h0} + (pos & msk);
  endfunction : byte_addr

  function automatic logic size_legal(input logic [7:0] cfg);
    logic [3:0] e1;
    logic [3:0] e2;
    e1 = cfg[uefp_pkg::EP1_SZ_LSB +: 4];
    e2 = cfg[uefp_pkg::EP2_SZ_LSB +: 4];
    return (e1 == uefp_pkg::SZ_16 && (e2 == uefp_pkg::SZ_16 || e2 == uefp_pkg::SZ_ZERO))
        || (e1 == uefp_pkg::SZ_32 && e2 == uefp_pkg::SZ_ZERO);
  endfunction : size_legal

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    logic [1:0]  ep;
    logic [5:0]  sz;
    logic [5:0]  ad;
    logic [7:0]  wbyte;
    logic [31:0] rd;
    logic        hit;
    logic [7:0]  dirv;
    st_next = st_reg;
    ep      = 2'h0;
    sz      = 6'h00;
    ad      = 6'h00;
    wbyte   = S_AXI_WDATA[7:0];
    rd      = 32'h00000000;
    hit     = 1'b1;
    dirv    = uefp_pkg::DIR_FIXED_ONES;
    st_next.eng_dv = 1'b0;

    // Engine writes OUT data; it stays invisible to the CPU until the ACK.
    ep = ENG_WR_EP;
    sz = fifo_size(st_reg.size_cfg, ep);
    if (ENG_WR && is_out(st_reg.ep2_dir, ep) && (st_reg.wp[ep] - st_reg.rc[ep]) < sz
        && (st_reg.wp[ep] - st_reg.wc[ep]) < (sz >> 1)) begin
      ad = byte_addr(st_reg.size_cfg, ep, st_reg.wp[ep]);
      st_next.mem[ad] = ENG_WR_DATA;
      st_next.wp[ep]  = st_reg.wp[ep] + 6'h01;
    end
    if (ENG_OUT_ERR) begin
      st_next.wp[ep] = st_reg.wc[ep];
    end else if (ENG_OUT_ACK) begin
      st_next.wc[ep] = st_next.wp[ep];
    end

    // Engine reads committed IN data; the ACK frees it, an error replays it.
    ep = ENG_RD_EP;
    sz = fifo_size(st_reg.size_cfg, ep);
    if (ENG_RD && !is_out(st_reg.ep2_dir, ep) && st_reg.rp[ep] != st_reg.wc[ep]
        && (st_reg.rp[ep] - st_reg.rc[ep]) < (sz >> 1)) begin
      ad = byte_addr(st_reg.size_cfg, ep, st_reg.rp[ep]);
      st_next.eng_data = st_reg.mem[ad];
      st_next.eng_dv   = 1'b1;
      st_next.rp[ep]   = st_reg.rp[ep] + 6'h01;
    end
    if (ENG_IN_ERR) begin
      st_next.rp[ep] = st_reg.rc[ep];
    end else if (ENG_IN_ACK) begin
      st_next.rc[ep] = st_next.rp[ep];
    end

    // Bus write: both channels are taken together in one cycle.
    if (st_reg.bvld && S_AXI_BREADY) begin
      st_next.bvld = 1'b0;
    end
    st_next.awrdy = 1'b0;
    if (st_reg.awrdy) begin
      st_next.bvld  = 1'b1;
      st_next.bresp = uefp_pkg::RESP_OKAY;
      ep = S_AXI_AWADDR[3:2] - 2'h1;
      unique case (S_AXI_AWADDR)
        uefp_pkg::OFS_SIZE_CFG: begin
          if (S_AXI_WSTRB[0] && size_legal(wbyte) && wbyte != st_reg.size_cfg) begin
            st_next.size_cfg = wbyte;
            for (int k = 2; k < 4; k++) begin
              st_next.wp[k] = 6'h00;
              st_next.wc[k] = 6'h00;
              st_next.rp[k] = 6'h00;
              st_next.rc[k] = 6'h00;
            end
          end
        end
        uefp_pkg::OFS_EP0_IN, uefp_pkg::OFS_EP0_OUT, uefp_pkg::OFS_EP1_IN,
        uefp_pkg::OFS_EP2_DATA: begin
          sz = fifo_size(st_reg.size_cfg, ep);
          // Writes to a port in its read direction are dropped.
          if (S_AXI_WSTRB[0] && !is_out(st_reg.ep2_dir, ep)
              && (st_reg.wp[ep] - st_reg.rc[ep]) < sz) begin
            ad = byte_addr(st_reg.size_cfg, ep, st_reg.wp[ep]);
            st_next.mem[ad] = wbyte;
            st_next.wp[ep]  = st_reg.wp[ep] + 6'h01;
          end
        end
        uefp_pkg::OFS_TX_ENABLE: begin
          if (S_AXI_WSTRB[0] && wbyte[uefp_pkg::TE_EP0_BIT]) begin
            st_next.wc[0] = st_reg.wp[0];
          end
          if (S_AXI_WSTRB[0] && wbyte[uefp_pkg::TE_EP1_BIT]) begin
            st_next.wc[2] = st_reg.wp[2];
          end
          if (S_AXI_WSTRB[0] && wbyte[uefp_pkg::TE_EP2_BIT] && st_reg.ep2_dir) begin
            st_next.wc[3] = st_reg.wp[3];
          end
        end
        uefp_pkg::OFS_DIRECTION: begin
          if (S_AXI_WSTRB[0] && wbyte[uefp_pkg::EP2_DIR_BIT] != st_reg.ep2_dir) begin
            st_next.ep2_dir = wbyte[uefp_pkg::EP2_DIR_BIT];
            st_next.wp[3] = 6'h00;
            st_next.wc[3] = 6'h00;
            st_next.rp[3] = 6'h00;
            st_next.rc[3] = 6'h00;
          end
        end
        uefp_pkg::OFS_SOFT_RESET: begin
          if (S_AXI_WSTRB[0] && wbyte[uefp_pkg::SOFT_RST_BIT]) begin
            st_next.mem      = '0;
            st_next.wp       = '0;
            st_next.wc       = '0;
            st_next.rp       = '0;
            st_next.rc       = '0;
            st_next.size_cfg = uefp_pkg::SIZE_CFG_RST;
            st_next.ep2_dir  = uefp_pkg::EP2_DIR_RST;
          end
        end
        default: begin
          st_next.bresp = uefp_pkg::RESP_DECERR;
        end
      endcase
    end else if (!st_reg.bvld && S_AXI_AWVALID && S_AXI_WVALID) begin
      st_next.awrdy = 1'b1;
    end

    // Bus read.
    if (st_reg.rvld && S_AXI_RREADY) begin
      st_next.rvld = 1'b0;
    end
    st_next.arrdy = 1'b0;
    if (st_reg.arrdy) begin
      st_next.rvld  = 1'b1;
      st_next.rresp = uefp_pkg::RESP_OKAY;
      ep = S_AXI_ARADDR[3:2] - 2'h1;
      unique case (S_AXI_ARADDR)
        uefp_pkg::OFS_SIZE_CFG: begin
          rd[7:0] = st_reg.size_cfg;
        end
        uefp_pkg::OFS_EP0_IN, uefp_pkg::OFS_EP0_OUT, uefp_pkg::OFS_EP1_IN,
        uefp_pkg::OFS_EP2_DATA: begin
          // Write-direction ports and empty ports read zero.
          if (is_out(st_reg.ep2_dir, ep) && st_reg.rp[ep] != st_reg.wc[ep]) begin
            ad = byte_addr(st_reg.size_cfg, ep, st_reg.rp[ep]);
            rd[7:0] = st_reg.mem[ad];
            st_next.rp[ep] = st_reg.rp[ep] + 6'h01;
            st_next.rc[ep] = st_reg.rp[ep] + 6'h01;
          end
        end
        uefp_pkg::OFS_TX_ENABLE, uefp_pkg::OFS_SOFT_RESET: begin
          rd = 32'h00000000;
        end
        uefp_pkg::OFS_DIRECTION: begin
          dirv[uefp_pkg::EP2_DIR_BIT] = st_reg.ep2_dir;
          rd[7:0] = dirv;
        end
        uefp_pkg::OFS_STATUS: begin
          rd[uefp_pkg::ST_EP0_LSB +: 6] = st_reg.wc[1] - st_reg.rp[1];
          rd[uefp_pkg::ST_EP2_LSB +: 6] = is_out(st_reg.ep2_dir, 2'h3)
                                        ? (st_reg.wc[3] - st_reg.rp[3]) : 6'h00;
        end
        default: begin
          hit = 1'b0;
        end
      endcase
      st_next.rdata = rd;
      if (!hit) begin
        st_next.rresp = uefp_pkg::RESP_DECERR;
      end
    end else if (!st_reg.rvld && S_AXI_ARVALID) begin
      st_next.arrdy = 1'b1;
    end

    // Engine-facing flags, taken from the settled next pointers.
    for (int k = 0; k < 4; k++) begin
      ep = 2'(k);
      sz = fifo_size(st_next.size_cfg, ep);
      st_next.in_rdy[k]   = !is_out(st_next.ep2_dir, ep) && st_next.rp[k] != st_next.wc[k];
      st_next.out_room[k] = is_out(st_next.ep2_dir, ep)
                            && (st_next.wp[k] - st_next.rc[k]) < sz;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      st_reg <= uefp_pkg::STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign S_AXI_AWREADY = st_reg.awrdy;
  assign S_AXI_WREADY  = st_reg.awrdy;
  assign S_AXI_BVALID  = st_reg.bvld;
  assign S_AXI_BRESP   = st_reg.bresp;
  assign S_AXI_ARREADY = st_reg.arrdy;
  assign S_AXI_RVALID  = st_reg.rvld;
  assign S_AXI_RRESP   = st_reg.rresp;
  assign S_AXI_RDATA   = st_reg.rdata;
  assign ENG_RD_DATA   = st_reg.eng_data;
  assign ENG_RD_VALID  = st_reg.eng_dv;
  assign ENG_IN_READY  = st_reg.in_rdy;
  assign ENG_OUT_ROOM  = st_reg.out_room;

endmodule : uefp_top

`default_nettype wire

// ==== verification/test_usb_endpoint_fifo_ports.sv ====
// Testbench for the endpoint FIFO block: CPU side over AXI4-Lite, engine side by the model.
// Assumes uefp_top and uefp_eng_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_usb_endpoint_fifo_ports;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rd, in_ack, in_err, wr, out_ack, out_err;
  logic rd_valid;
  logic [1:0] bresp, rresp, rd_ep, wr_ep, r;
  logic [31:0] rdata, v;
  logic [7:0] rd_data, wr_data;
  logic [3:0] in_ready, out_room;
  int error_cnt = 0;
  int check_count = 0;
  uefp_top i_uefp_top (.REF_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .ENG_RD_EP(rd_ep), .ENG_RD(rd), .ENG_IN_ACK(in_ack),
    .ENG_IN_ERR(in_err), .ENG_RD_DATA(rd_data), .ENG_RD_VALID(rd_valid), .ENG_WR_EP(wr_ep),
    .ENG_WR(wr), .ENG_WR_DATA(wr_data), .ENG_OUT_ACK(out_ack), .ENG_OUT_ERR(out_err),
    .ENG_IN_READY(in_ready), .ENG_OUT_ROOM(out_room));
  uefp_eng_model i_uefp_eng_model (.clk(clk), .rd_ep(rd_ep), .rd(rd), .in_ack(in_ack),
    .in_err(in_err), .rd_data(rd_data), .rd_valid(rd_valid), .wr_ep(wr_ep), .wr(wr),
    .wr_data(wr_data), .out_ack(out_ack), .out_err(out_err));
  always #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    @(posedge clk);
    while (awready !== 1'b1) @(posedge clk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    @(posedge clk);
    while (bvalid !== 1'b1) @(posedge clk);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge clk);
    while (arready !== 1'b1) @(posedge clk);
    arvalid <= 1'b0;
    @(posedge clk);
    while (rvalid !== 1'b1) @(posedge clk);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask : rd_reg
  function automatic logic [15:0] n_got();
    return 16'(i_uefp_eng_model.got.size());
  endfunction : n_got
  function automatic logic [15:0] got(input int k);
    return {8'h00, i_uefp_eng_model.got[k]};
  endfunction : got
  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [7:0] ad[8] = '{8'h00, 8'h18, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h24};
    logic [7:0] ex[8] = '{8'h44, 8'hFC, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) begin
      rd_reg(ad[i]);
      chk("reset value", v[15:0], {8'h00, ex[i]});
      chk("resp", {14'h0, r}, i == 7 ? 16'h3 : 16'h0);
    end
    chk("in ready", {12'h0, in_ready}, 16'h0);
    chk("out room", {12'h0, out_room}, 16'h2);
    wr_reg(8'h24, 8'h01);
    chk("wr resp", {14'h0, r}, 16'h3);
  endtask : t_reset
  task automatic t_size;
    logic [7:0] bad[3] = '{8'h45, 8'h04, 8'h66};
    wr_reg(8'h00, 8'h50);
    rd_reg(8'h00);
    chk("size", v[15:0], 16'h50);
    foreach (bad[i]) begin
      wr_reg(8'h00, bad[i]);
      rd_reg(8'h00);
      chk("bad code", v[15:0], 16'h50);
    end
    for (int i = 0; i < 20; i++) wr_reg(8'h0C, 8'(i));
    wr_reg(8'h14, 8'h04);
    i_uefp_eng_model.fetch(2'h2, 20, 1'b0);
    chk("ep1 pkt", n_got(), 16'h10);
    chk("ep1 byte", got(15), 16'h0F);
    wr_reg(8'h00, 8'h44);
  endtask : t_size
  task automatic t_in;
    for (int i = 0; i < 9; i++) wr_reg(8'h04, 8'h10 + 8'(i));
    i_uefp_eng_model.fetch(2'h0, 1, 1'b1);
    chk("before enable", n_got(), 16'h0);
    rd_reg(8'h04);
    chk("wo port", v[15:0], 16'h0);
    wr_reg(8'h14, 8'h02);
    rd_reg(8'h14);
    chk("enable reads", v[15:0], 16'h0);
    chk("in ready", {12'h0, in_ready}, 16'h1);
    i_uefp_eng_model.fetch(2'h0, 9, 1'b1);
    chk("ep0 pkt", n_got(), 16'h8);
    i_uefp_eng_model.fetch(2'h0, 9, 1'b0);
    chk("rewound", got(0), 16'h10);
    chk("order", got(7), 16'h17);
    i_uefp_eng_model.fetch(2'h0, 1, 1'b0);
    chk("rest", got(0), 16'h18);
  endtask : t_in
  task automatic t_out;
    i_uefp_eng_model.fetch(2'h1, 1, 1'b1);
    chk("out fifo", n_got(), 16'h0);
    i_uefp_eng_model.send(2'h1, 8'hC0, 3, 1'b1);
    rd_reg(8'h20);
    chk("err drop", v[15:0], 16'h0);
    i_uefp_eng_model.send(2'h1, 8'hC0, 3, 1'b0);
    wr_reg(8'h08, 8'h77);
    rd_reg(8'h20);
    chk("acked", v[15:0], 16'h3);
    for (int i = 0; i < 4; i++) begin
      rd_reg(8'h08);
      chk("out byte", v[15:0], i < 3 ? 16'hC0 + 16'(i) : 16'h0);
    end
  endtask : t_out
  task automatic t_ep2;
    wr_reg(8'h18, 8'h00);
    rd_reg(8'h18);
    chk("dir", v[15:0], 16'hF4);
    chk("out room", {12'h0, out_room}, 16'hA);
    i_uefp_eng_model.send(2'h3, 8'hE0, 2, 1'b0);
    wr_reg(8'h10, 8'h55);
    rd_reg(8'h20);
    chk("ep2 count", v[15:0], 16'h0200);
    rd_reg(8'h10);
    chk("ep2 byte", v[15:0], 16'hE0);
    wr_reg(8'h18, 8'h08);
    wr_reg(8'h10, 8'h3C);
    rd_reg(8'h10);
    chk("ep2 wo", v[15:0], 16'h0);
    wr_reg(8'h14, 8'h08);
    i_uefp_eng_model.fetch(2'h3, 2, 1'b0);
    chk("ep2 in cnt", n_got(), 16'h1);
    chk("ep2 in", got(0), 16'h3C);
  endtask : t_ep2
  task automatic t_soft;
    wr_reg(8'h00, 8'h50);
    wr_reg(8'h04, 8'h99);
    wr_reg(8'h1C, 8'h01);
    rd_reg(8'h00);
    chk("soft size", v[15:0], 16'h44);
    wr_reg(8'h14, 8'h02);
    i_uefp_eng_model.fetch(2'h0, 1, 1'b0);
    chk("soft clear", n_got(), 16'h0);
  endtask : t_soft
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_size;
    t_in;
    t_out;
    t_ep2;
    t_soft;
    final_report;
  end
  // The whole sequence needs well under two thousand cycles.
  initial begin
    repeat (8000) @(posedge clk);
    error_cnt++;
    final_report;
  end
endmodule : test_usb_endpoint_fifo_ports
`default_nettype wire

// ==== verification/uefp_eng_model.sv ====
// Model of the USB function engine that moves bytes in and out of the fifos.
// Assumes its tasks are called just after a rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module uefp_eng_model (
  input  wire logic       clk,
  output logic [1:0]      rd_ep,
  output logic            rd,
  output logic            in_ack,
  output logic            in_err,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid,
  output logic [1:0]      wr_ep,
  output logic            wr,
  output logic [7:0]      wr_data,
  output logic            out_ack,
  output logic            out_err
);
  logic [7:0] got[$];
  initial begin
    {rd_ep, rd, in_ack, in_err, wr_ep, wr, out_ack, out_err} = '0;
    wr_data = 8'hA5;
  end
  always @(posedge clk) if (rd_valid === 1'b1) got.push_back(rd_data);
  ////////////////////////////////////////////////////////////
  task automatic send(input logic [1:0] ep, input logic [7:0] b0, input int n, input logic bad);
    for (int i = 0; i < n; i++) begin
      wr <= 1'b1;
      wr_ep <= ep;
      wr_data <= b0 + 8'(i);
      @(posedge clk);
    end
    wr <= 1'b0;
    // A released data bus does not keep the last byte.
    wr_data <= ~wr_data;
    out_ack <= !bad;
    out_err <= bad;
    @(posedge clk);
    out_ack <= 1'b0;
    out_err <= 1'b0;
    @(posedge clk);
  endtask : send
  task automatic fetch(input logic [1:0] ep, input int n, input logic bad);
    got.delete();
    for (int i = 0; i < n; i++) begin
      rd <= 1'b1;
      rd_ep <= ep;
      @(posedge clk);
    end
    rd <= 1'b0;
    @(posedge clk);
    in_ack <= !bad;
    in_err <= bad;
    @(posedge clk);
    in_ack <= 1'b0;
    in_err <= 1'b0;
    @(posedge clk);
  endtask : fetch
endmodule : uefp_eng_model
`default_nettype wire

// ==== verification/uefp_top_asserts.sv ====
// Checker for the endpoint FIFO block, watching the top module ports only.
// Assumes a single REF_CLK domain with RST as its asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module uefp_checker (
  input wire logic       REF_CLK,
  input wire logic       RST,
  input wire logic       S_AXI_AWREADY,
  input wire logic       S_AXI_WREADY,
  input wire logic       S_AXI_BVALID,
  input wire logic       S_AXI_BREADY,
  input wire logic       S_AXI_ARREADY,
  input wire logic       S_AXI_RVALID,
  input wire logic [1:0] ENG_RD_EP,
  input wire logic       ENG_RD,
  input wire logic       ENG_IN_ACK,
  input wire logic       ENG_IN_ERR,
  input wire logic       ENG_RD_VALID,
  input wire logic [3:0] ENG_IN_READY
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////
  // Bytes handed out since the last commit or rewind; 16 is the largest packet.
  logic [5:0] sent_reg;
  logic [5:0] sent_next;
  always_comb begin
    sent_next = sent_reg + {5'h00, ENG_RD_VALID};
    if (ENG_IN_ACK || ENG_IN_ERR) begin
      sent_next = 6'h00;
    end
  end
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      sent_reg <= 6'h00;
    end else begin
      sent_reg <= sent_next;
    end
  end
  ////////////////////////////////////////////////////////////
  property p_rd_cause; ENG_RD_VALID |-> $past(ENG_RD); endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("byte without request.");
  property p_rdv_one; ENG_RD_VALID && !ENG_RD |=> !ENG_RD_VALID; endproperty
  a_rdv_one: assert property (p_rdv_one) else $error("byte strobe too long.");
  property p_no_out; ENG_RD && ENG_RD_EP == 2'h1 |=> !ENG_RD_VALID; endproperty
  a_no_out: assert property (p_no_out) else $error("out fifo sent a byte.");
  property p_pkt; sent_reg <= 6'h10; endproperty
  a_pkt: assert property (p_pkt) else $error("packet over half the fifo.");
  property p_rst; $fell(RST) |-> ENG_IN_READY == 4'h0 && !S_AXI_BVALID; endproperty
  a_rst: assert property (p_rst) else $error("state not clear after reset.");
  property p_wr; S_AXI_AWREADY |-> S_AXI_WREADY ##1 S_AXI_BVALID; endproperty
  a_wr: assert property (p_wr) else $error("write not answered.");
  property p_bdone; S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID; endproperty
  a_bdone: assert property (p_bdone) else $error("write answer repeated.");
  property p_rd; S_AXI_ARREADY |=> S_AXI_RVALID [*1]; endproperty
  a_rd: assert property (p_rd) else $error("read not answered.");
endmodule : uefp_checker

bind uefp_top uefp_checker i_uefp_checker (.REF_CLK(REF_CLK), .RST(RST),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
  .ENG_RD_EP(ENG_RD_EP), .ENG_RD(ENG_RD), .ENG_IN_ACK(ENG_IN_ACK), .ENG_IN_ERR(ENG_IN_ERR),
  .ENG_RD_VALID(ENG_RD_VALID), .ENG_IN_READY(ENG_IN_READY));
`default_nettype wire
